// ===== pbhh_hold.sv
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// [R1] release request sampled synchronously, late means cycle later
// [R2] inhibit bit ends hold, refuses new holds
// [R3] no bus access during hold; stall on need
// [R4] one write may pend; second write stalls
// [R5] request captured one cycle before cycle end
// [R6] requester holds request until grant seen
// [R7] requester keeps request low three cycles
// [R8] grant low at least two cycles, clocked
// [R9] strobe driven high first, then floated
// [R10] rnw, address and data floated when granting
// [R11] outputs re-enabled before bus use resumes
// [R12] grant ends one cycle after request rises; code raises grant two clocks after the sampled request falls
module pbhh_hold (
   input wire logic clk,
   input wire logic reset,
   input wire logic bus_release_request_n,
   input wire logic release_inhibit,
   input wire logic [pbhh_pkg::PBHH_WAIT_W-1:0] wait_state_count,
   input wire pbhh_pkg::pbhh_req_t cpu_req,
   output logic cpu_stall,
   output logic bus_release_grant_n,
   output logic bus_strobe_n,
   output logic bus_rnw,
   output logic [pbhh_pkg::PBHH_ADDR_W-1:0] bus_addr,
   output logic [pbhh_pkg::PBHH_DATA_W-1:0] bus_wdata,
   output pbhh_pkg::pbhh_pad_oe_t pad_oe,
   output logic write_pending
);
   pbhh_pkg::pbhh_state_t state_reg;
   logic req_reg;
   logic [1:0] grant_cnt_reg;
   logic [pbhh_pkg::PBHH_WAIT_W-1:0] wait_cnt_reg;
   logic busy_reg;
   pbhh_pkg::pbhh_req_t pend_reg;
   logic grant_reg;
   logic last_cycle;
   logic in_hold;
   logic take_req;

   // request sampled once; the request pin is treated as synchronous
   always_ff @(posedge clk) begin
      if (reset) begin
         req_reg <= 1'b0;
      end else begin
         req_reg <= ~bus_release_request_n & ~release_inhibit; // R1 R2
      end
   end

   // bus cycle timing: each access lasts wait_state_count + 1 cycles
   assign last_cycle = busy_reg && (wait_cnt_reg == wait_state_count);
   assign in_hold = (state_reg != pbhh_pkg::PBHH_IDLE);
   // hold taken at a cycle boundary: during last cycle or when bus idle
   assign take_req = req_reg && (!busy_reg || last_cycle); // R5

   always_ff @(posedge clk) begin
      if (reset) begin
         busy_reg <= 1'b0;
         wait_cnt_reg <= pbhh_pkg::PBHH_WAIT_CNT_RST;
         bus_rnw <= 1'b1;
         bus_addr <= '0;
         bus_wdata <= '0;
         bus_strobe_n <= 1'b1;
      end else if (busy_reg && !last_cycle) begin
         wait_cnt_reg <= wait_cnt_reg + 3'h1;
      end else if (!in_hold && !take_req && pend_reg.valid) begin
         // held write goes out first once the bus is back
         busy_reg <= 1'b1; // R4
         wait_cnt_reg <= pbhh_pkg::PBHH_WAIT_CNT_RST;
         bus_rnw <= 1'b0;
         bus_addr <= pend_reg.addr;
         bus_wdata <= pend_reg.wdata;
         bus_strobe_n <= 1'b0;
      end else if (!in_hold && !take_req && cpu_req.valid) begin
         busy_reg <= 1'b1;
         wait_cnt_reg <= pbhh_pkg::PBHH_WAIT_CNT_RST;
         bus_rnw <= ~cpu_req.write;
         bus_addr <= cpu_req.addr;
         bus_wdata <= cpu_req.wdata;
         bus_strobe_n <= 1'b0;
      end else begin
         busy_reg <= 1'b0;
         bus_strobe_n <= 1'b1; // R9
      end
   end

   // one write parked while the bus is held
   always_ff @(posedge clk) begin
      if (reset) begin
         pend_reg <= '0;
      end else if (!in_hold && !take_req && !(busy_reg && !last_cycle)) begin
         pend_reg.valid <= 1'b0;
      end else if (in_hold && cpu_req.valid && cpu_req.write && !pend_reg.valid) begin
         pend_reg <= cpu_req; // R4
      end
   end

   // hold sequence: strobe high, float, hold, re-enable
   always_ff @(posedge clk) begin
      if (reset) begin
         state_reg <= pbhh_pkg::PBHH_IDLE;
      end else begin
         case (state_reg)
            pbhh_pkg::PBHH_IDLE: begin
               if (take_req) begin
                  state_reg <= pbhh_pkg::PBHH_STROBE_HIGH; // R9
               end
            end
            pbhh_pkg::PBHH_STROBE_HIGH: begin
               state_reg <= pbhh_pkg::PBHH_FLOAT; // R10
            end
            pbhh_pkg::PBHH_FLOAT: begin
               state_reg <= pbhh_pkg::PBHH_HOLD;
            end
            pbhh_pkg::PBHH_HOLD: begin
               // minimum grant width kept even if inhibit arrives
               if ((!req_reg || release_inhibit) && grant_cnt_reg == 2'h0) begin
                  state_reg <= pbhh_pkg::PBHH_RELEASE; // R2 R8 R12
               end
            end
            pbhh_pkg::PBHH_RELEASE: begin
               state_reg <= pbhh_pkg::PBHH_IDLE; // R11
            end
            default: begin
               state_reg <= pbhh_pkg::PBHH_IDLE;
            end
         endcase
      end
   end

   // grant register, counts its own minimum low time
   always_ff @(posedge clk) begin
      if (reset) begin
         grant_reg <= 1'b0;
         grant_cnt_reg <= pbhh_pkg::PBHH_GRANT_CNT_RST;
      end else if (state_reg == pbhh_pkg::PBHH_FLOAT) begin
         grant_reg <= 1'b1;
         grant_cnt_reg <= 2'(pbhh_pkg::PBHH_GRANT_MIN_CYC - 1); // R8
      end else if (state_reg == pbhh_pkg::PBHH_RELEASE) begin
         grant_reg <= 1'b0; // R12
      end else if (grant_cnt_reg != 2'h0) begin
         grant_cnt_reg <= grant_cnt_reg - 2'h1;
      end
   end

   assign bus_release_grant_n = ~grant_reg;

   // pads float from the float state through the release state
   always_comb begin
      pad_oe.strobe_oe = (state_reg == pbhh_pkg::PBHH_IDLE)
         || (state_reg == pbhh_pkg::PBHH_STROBE_HIGH); // R9 R11
      pad_oe.rnw_oe = pad_oe.strobe_oe; // R10
      pad_oe.addr_oe = pad_oe.strobe_oe; // R10
      pad_oe.data_oe = pad_oe.strobe_oe && busy_reg && !bus_rnw; // R10
   end

   // stall on any access in hold except the first parked write
   assign cpu_stall = cpu_req.valid && (in_hold || take_req
      || (busy_reg && !last_cycle) || pend_reg.valid)
      && !(in_hold && cpu_req.write && !pend_reg.valid); // R3 R4
   assign write_pending = pend_reg.valid;

   property p_grant_min;
      @(posedge clk) disable iff (reset)
         $fell(bus_release_grant_n) |=> !bus_release_grant_n;
   endproperty
   a_grant_min: assert property (p_grant_min) else $error("grant too short"); // R8

   property p_strobe_high_first;
      @(posedge clk) disable iff (reset)
         $fell(pad_oe.strobe_oe) |-> $past(bus_strobe_n);
   endproperty
   a_strobe_high_first: assert property (p_strobe_high_first) // R9
      else $error("strobe floated while low");

   property p_float_in_grant;
      @(posedge clk) disable iff (reset)
         !bus_release_grant_n |-> !pad_oe.addr_oe && !pad_oe.rnw_oe && !pad_oe.data_oe;
   endproperty
   a_float_in_grant: assert property (p_float_in_grant) // R10 R3
      else $error("bus driven during grant");

   property p_inhibit;
      @(posedge clk) disable iff (reset)
         release_inhibit && state_reg == pbhh_pkg::PBHH_IDLE |=>
            state_reg == pbhh_pkg::PBHH_IDLE;
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("hold entered while inhibited"); // R2

   property p_grant_release;
      @(posedge clk) disable iff (reset)
         !bus_release_grant_n && req_reg ##1 !req_reg && !release_inhibit
            |-> ##[1:3] bus_release_grant_n;
   endproperty
   a_grant_release: assert property (p_grant_release) // R12
      else $error("grant kept too long");

   property p_reenable;
      @(posedge clk) disable iff (reset)
         $rose(bus_release_grant_n) |=> pad_oe.addr_oe && pad_oe.strobe_oe;
   endproperty
   a_reenable: assert property (p_reenable) else $error("pads not re-enabled"); // R11

   property p_grant_response;
      @(posedge clk) disable iff (reset)
         take_req && state_reg == pbhh_pkg::PBHH_IDLE |-> ##3 !bus_release_grant_n;
   endproperty
   a_grant_response: assert property (p_grant_response) else $error("grant late"); // R1 R5

   property p_one_pending;
      @(posedge clk) disable iff (reset)
         pend_reg.valid && in_hold && cpu_req.valid && cpu_req.write |-> cpu_stall;
   endproperty
   a_one_pending: assert property (p_one_pending) else $error("second write not stalled"); // R4

endmodule // pbhh_hold

`default_nettype wire

// ===== pbhh_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// outside master: request low at least 3 cycles and until grant seen
module pbhh_master_model (
   input wire logic clk,
   input wire logic reset,
   input wire logic start,
   input wire logic [7:0] min_low,
   input wire logic grant_n,
   output logic req_n
);
   logic [7:0] low_reg;
   logic [1:0] seen_reg;
   always_ff @(negedge clk) begin
      if (reset) begin
         req_n <= 1'h1;
         low_reg <= 8'h00;
         seen_reg <= 2'h0;
      end else if (req_n) begin
         req_n <= !start;
         low_reg <= 8'h01;
         seen_reg <= 2'h0;
      end else begin
         low_reg <= low_reg + 8'h01;
         if (!grant_n && seen_reg != 2'h3) seen_reg <= seen_reg + 2'h1;
         // two grant samples cover one full grant cycle
         if (low_reg >= 8'h03 && low_reg >= min_low && seen_reg >= 2'h2) req_n <= 1'h1;
      end
   end
endmodule // pbhh_master_model
`default_nettype wire

// ===== pbhh_pkg.sv
package pbhh_pkg;
   // bus hold states
   typedef enum logic [2:0] {
      PBHH_IDLE,
      PBHH_STROBE_HIGH,
      PBHH_FLOAT,
      PBHH_HOLD,
      PBHH_RELEASE
   } pbhh_state_t;

   // cpu side bus request
   typedef struct packed {
      logic valid;
      logic write;
      logic [23:0] addr;
      logic [31:0] wdata;
   } pbhh_req_t;

   // pad enables toward the bus pins
   typedef struct packed {
      logic strobe_oe;
      logic rnw_oe;
      logic addr_oe;
      logic data_oe;
   } pbhh_pad_oe_t;

   localparam int PBHH_ADDR_W = 24;
   localparam int PBHH_DATA_W = 32;
   localparam int PBHH_WAIT_W = 3;
   localparam int PBHH_GRANT_MIN_CYC = 2;
   localparam int PBHH_REQ_MIN_CYC = 3;
   localparam logic [1:0] PBHH_GRANT_CNT_RST = 2'h0;
   localparam logic [2:0] PBHH_WAIT_CNT_RST = 3'h0;
endpackage

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk = 1'h0, reset = 1'h1, inh = 1'h0, start = 1'h0, req_n, stall, grant_n, stb_n;
   logic rnw, wpend, last;
   logic [2:0] wsc = 3'h0;
   logic [7:0] min_low = 8'h05;
   logic [23:0] addr;
   logic [31:0] wdata;
   logic [23:0] seen_q[$];
   pbhh_pkg::pbhh_req_t req = '0;
   pbhh_pkg::pbhh_pad_oe_t oe;
   int mismatches = 0, comparisons = 0, cycles = 0, n, k;
   always #12.5 clk = ~clk;
   pbhh_hold pbhh_hold_i (.clk(clk), .reset(reset), .bus_release_request_n(req_n),
      .release_inhibit(inh), .wait_state_count(wsc), .cpu_req(req), .cpu_stall(stall),
      .bus_release_grant_n(grant_n), .bus_strobe_n(stb_n), .bus_rnw(rnw), .bus_addr(addr),
      .bus_wdata(wdata), .pad_oe(oe), .write_pending(wpend));
   pbhh_master_model pbhh_master_model_i (.clk(clk), .reset(reset), .start(start),
      .min_low(min_low), .grant_n(grant_n), .req_n(req_n));
   task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic wait_grant(logic val);
      for (k = 0; grant_n !== val && k < 40; k++) @(negedge clk);
      chk("grant", grant_n, val);
   endtask
   task automatic go;
      start <= 1'h1;
      @(negedge clk);
      start <= 1'h0;
   endtask
   task automatic t_reset;
      chk("grant", grant_n, 1'h1);
      chk("strobe", stb_n, 1'h1);
      chk("pad_oe", oe, 4'he);
      chk("pending", wpend, 1'h0);
      $display("test reset done");
   endtask
   task automatic t_hold;
      min_low = 8'h05;
      go;
      wait_grant(1'h0);
      req = '{1'h1, 1'h0, 24'h000333, 32'h0};
      #1 chk("read stall", stall, 1'h1);
      for (n = 0, k = 0; grant_n === 1'h0 && n < 40; n++) begin
         chk("pad_oe", oe, 4'h0);
         if (req_n) k++;
         @(negedge clk);
         req.valid = 1'h0;
      end
      chk("grant width", n >= 2, 1'h1);
      chk("grant tail", k >= 1, 1'h1);
      repeat (2) @(negedge clk);
      chk("pad_oe", oe, 4'he);
      $display("test hold done");
   endtask
   task automatic t_park;
      min_low = 8'h0c;
      go;
      wait_grant(1'h0);
      req = '{1'h1, 1'h1, 24'h00a5a5, 32'h1234abcd};
      #1 chk("stall", stall, 1'h0);
      @(negedge clk);
      req.addr = 24'h00005a;
      #1 chk("stall", stall, 1'h1);
      chk("pending", wpend, 1'h1);
      last = 1'h1;
      for (n = 0, k = 0; n < 60; n++) begin
         @(negedge clk);
         if (k) req.valid = 1'h0;
         if (req.valid && stall === 1'h0) k = 1;
         // back to back accesses keep strobe low, so a new address marks a new access
         if (stb_n === 1'h0 && (last || addr !== seen_q[$])) begin
            seen_q.push_back(addr);
            chk("rnw", rnw, 1'h0);
            chk("wdata", wdata, 32'h1234abcd);
            chk("oe", oe, 4'hf);
         end
         last = stb_n;
      end
      chk("writes", seen_q.size(), 2);
      chk("first", seen_q[0], 24'h00a5a5);
      chk("second", seen_q[1], 24'h00005a);
      $display("test park done");
   endtask
   task automatic t_wait;
      wsc = 3'h3;
      min_low = 8'h06;
      req = '{1'h1, 1'h0, 24'h000777, 32'h0};
      go;
      req.valid = 1'h0;
      for (n = 0, k = 0; grant_n !== 1'h0 && k < 40; k++) begin
         if (stb_n === 1'h0) begin
            n++;
            chk("read addr", {rnw, addr}, 25'h1000777);
         end
         @(negedge clk);
      end
      chk("strobe width", n, 4);
      wait_grant(1'h1);
      wsc = 3'h0;
      $display("test wait done");
   endtask
   task automatic t_inhibit;
      inh = 1'h1;
      min_low = 8'h28;
      go;
      repeat (10) @(negedge clk);
      chk("grant", grant_n, 1'h1);
      inh = 1'h0;
      wait_grant(1'h0);
      repeat (3) @(negedge clk);
      inh = 1'h1;
      wait_grant(1'h1);
      chk("request", req_n, 1'h0);
      inh = 1'h0;
      wait_grant(1'h0);
      for (n = 0; !(req_n && grant_n) && n < 100; n++) @(negedge clk);
      repeat (4) @(negedge clk);
      chk("pad_oe", oe, 4'he);
      $display("test inhibit done");
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         mismatches++;
         give_verdict;
      end
   end
   initial begin
      repeat (12) @(negedge clk);
      reset <= 1'h0;
      @(negedge clk);
      t_reset;
      t_hold;
      t_park;
      t_wait;
      t_inhibit;
      give_verdict;
   end
endmodule // testbench
`default_nettype wire
